// >>> ims_pkg.sv
// constants and register layout for the master status flags block
//------------------------------------------------------------
//------------------------------------------------------------
package ims_pkg;

	// register byte addresses
	localparam logic [31:0] ADDR_STATUS    = 32'h40020804;
	localparam logic [31:0] ADDR_CONTROL   = 32'h40020800;
	localparam logic [31:0] ADDR_IRQ_STAT  = 32'h40020840;
	localparam logic [31:0] ADDR_IRQ_MASK  = 32'h40020844;

	// master_status_flags layout
	localparam int          BIT_CLK_FILT   = 14;
	localparam int          BIT_DAT_FILT   = 13;
	localparam int          BIT_TX_UFLOW   = 12;
	localparam int          BIT_SELF_STOP  = 11;
	localparam int          BIT_BUS_OCC    = 10;
	localparam int          BIT_RX_OFLOW   = 9;
	localparam logic [15:0] STATUS_RESET   = 16'h6000;

	// master_control_register layout
	localparam int          BIT_TXREQ_IEN  = 0;
	localparam int          BIT_CMP_IEN    = 1;
	localparam logic [1:0]  CONTROL_RESET  = 2'h0;

	// interrupt status / mask layout
	localparam int          IRQ_BITS       = 4;
	localparam int          IRQ_TX_BYTE    = 0;
	localparam int          IRQ_STOP       = 1;
	localparam int          IRQ_UFLOW      = 2;
	localparam int          IRQ_OFLOW      = 3;
	localparam logic [3:0]  IRQ_RESET      = 4'h0;

	// glitch filter length in clock cycles
	localparam int          FILT_CYCLES    = 4;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_READ = 2'b01,
		BUS_ACK  = 2'b10
	} ims_bus_type;

endpackage

// >>> ims_line_if.sv
// filtered bus line states and detected start/stop pulses
`timescale 1ns/1ps
`default_nettype none
interface ims_line_if;
	logic scl;
	logic sda;
	logic start;
	logic stop;
	modport det  (input scl, input sda, output start, output stop);
	modport core (input scl, input sda, input start, input stop);
endinterface
`default_nettype wire

// >>> ims_glitch_filter.sv
// two-stage synchroniser followed by a stability counter
`timescale 1ns/1ps
`default_nettype none
module ims_glitch_filter #(
	parameter int LEN = ims_pkg::FILT_CYCLES
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// line
	input  wire logic line,
	output var  logic filt
);
	logic       sync1_reg;
	logic       sync2_reg;
	logic [7:0] cnt_reg;

	// reset to one: an undriven line is pulled high
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else begin
			sync1_reg <= line;
			sync2_reg <= sync1_reg;
		end
	end

	// output follows only after LEN stable samples
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= 8'h00;
			filt    <= 1'b1;
		end else if (sync2_reg == filt) begin
			cnt_reg <= 8'h00;
		end else if (cnt_reg == 8'(LEN - 1)) begin
			cnt_reg <= 8'h00;
			filt    <= sync2_reg;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end
endmodule
`default_nettype wire

// >>> ims_cond_detect.sv
// start and stop condition detector on the filtered lines
`timescale 1ns/1ps
`default_nettype none
module ims_cond_detect (
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rst,
	// filtered lines and pulses
	ims_line_if.det    lines
);
	logic sda_d_reg;
	logic scl_d_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			sda_d_reg <= 1'b1;
			scl_d_reg <= 1'b1;
		end else begin
			sda_d_reg <= lines.sda;
			scl_d_reg <= lines.scl;
		end
	end

	// data edge while clock stays high marks a condition
	assign lines.start = sda_d_reg & ~lines.sda & scl_d_reg & lines.scl;
	assign lines.stop  = ~sda_d_reg & lines.sda & scl_d_reg & lines.scl;
endmodule
`default_nettype wire

// >>> ims_status_top.sv
// master status flags register block with wishbone slave and interrupt
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module ims_status_top #(
	parameter int FILT_LEN = ims_pkg::FILT_CYCLES
) (
	// clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	// wishbone slave
	input  wire logic [31:0] WB_ADR,
	input  wire logic [31:0] WB_DAT_W,
	input  wire logic [3:0]  WB_SEL,
	input  wire logic        WB_WE,
	input  wire logic        WB_CYC,
	input  wire logic        WB_STB,
	output var  logic [31:0] WB_DAT_R,
	output var  logic        WB_ACK,
	// bus line pins
	input  wire logic        SCL_IN,
	input  wire logic        SDA_IN,
	// events from the master state machine
	input  wire logic        TX_EMPTY_END,
	input  wire logic        SELF_STOP_DRIVEN,
	input  wire logic        RX_PUSH,
	input  wire logic        RX_FULL,
	input  wire logic        TX_BYTE_DONE,
	// control and interrupt
	output var  logic        TXREQ_IEN,
	output var  logic        CMP_IEN,
	output var  logic        IRQ
);
	ims_line_if lines ();

	ims_pkg::ims_bus_type bus_state_reg;

	logic [15:0]                  status_word;
	logic                         clk_filt_reg;
	logic                         dat_filt_reg;
	logic                         bus_occ_reg;
	logic                         uflow_reg;
	logic                         self_stop_reg;
	logic                         oflow_reg;
	logic [ims_pkg::IRQ_BITS-1:0] irq_stat_reg;
	logic [ims_pkg::IRQ_BITS-1:0] irq_mask_reg;
	logic [ims_pkg::IRQ_BITS-1:0] irq_event;
	logic [31:0]                  rd_data;
	logic                         req;
	logic                         acc;
	logic                         wr_en;
	logic                         rd_status;
	logic                         rd_irq;
	logic                         uflow_set;
	logic                         bus_occ_next;

	//------------------------------------------------------------
	// line filters and condition detection
	//------------------------------------------------------------
	ims_glitch_filter #(.LEN(FILT_LEN)) u_clk_filt (
		.clk  (CORE_CLK),
		.rst  (RST),
		.line (SCL_IN),
		.filt (lines.scl)
	);

	ims_glitch_filter #(.LEN(FILT_LEN)) u_dat_filt (
		.clk  (CORE_CLK),
		.rst  (RST),
		.line (SDA_IN),
		.filt (lines.sda)
	);

	ims_cond_detect u_detect (
		.clk   (CORE_CLK),
		.rst   (RST),
		.lines (lines)
	);

	//------------------------------------------------------------
	// wishbone slave: answer one cycle after the request
	//------------------------------------------------------------
	assign req = WB_CYC & WB_STB;
	// acc marks the one edge at which a request takes effect
	assign acc = req & (bus_state_reg == ims_pkg::BUS_IDLE);
	assign wr_en = acc & WB_WE;
	assign rd_status = acc & ~WB_WE & (WB_ADR == ims_pkg::ADDR_STATUS);
	assign rd_irq = acc & ~WB_WE & (WB_ADR == ims_pkg::ADDR_IRQ_STAT);

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			bus_state_reg <= ims_pkg::BUS_IDLE;
			WB_ACK        <= 1'b0;
		end else begin
			unique case (bus_state_reg)
				ims_pkg::BUS_IDLE: begin
					if (req) begin
						bus_state_reg <= ims_pkg::BUS_ACK;
						WB_ACK        <= 1'b1;
					end
				end
				ims_pkg::BUS_ACK: begin
					// drop ack after one cycle, wait for release
					WB_ACK        <= 1'b0;
					bus_state_reg <= ims_pkg::BUS_READ;
				end
				ims_pkg::BUS_READ: begin
					if (!req) begin
						bus_state_reg <= ims_pkg::BUS_IDLE;
					end
				end
				default: begin
					bus_state_reg <= ims_pkg::BUS_IDLE;
					WB_ACK        <= 1'b0;
				end
			endcase
		end
	end

	// unmapped addresses read as zero and ignore writes
	always_comb begin
		rd_data = 32'h00000000;
		unique case (WB_ADR)
			ims_pkg::ADDR_STATUS:   rd_data[15:0] = status_word;
			ims_pkg::ADDR_CONTROL: begin
				rd_data[ims_pkg::BIT_TXREQ_IEN] = TXREQ_IEN;
				rd_data[ims_pkg::BIT_CMP_IEN]   = CMP_IEN;
			end
			ims_pkg::ADDR_IRQ_STAT: rd_data[ims_pkg::IRQ_BITS-1:0] = irq_stat_reg;
			ims_pkg::ADDR_IRQ_MASK: rd_data[ims_pkg::IRQ_BITS-1:0] = irq_mask_reg;
			default:                rd_data = 32'h00000000;
		endcase
	end

	// data is captured at the same edge that clears the flags
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			WB_DAT_R <= 32'h00000000;
		end else if (acc && !WB_WE) begin
			WB_DAT_R <= rd_data;
		end
	end

	//------------------------------------------------------------
	// control register
	//------------------------------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			TXREQ_IEN <= ims_pkg::CONTROL_RESET[ims_pkg::BIT_TXREQ_IEN];
			CMP_IEN   <= ims_pkg::CONTROL_RESET[ims_pkg::BIT_CMP_IEN];
		end else if (wr_en && WB_ADR == ims_pkg::ADDR_CONTROL && WB_SEL[0]) begin
			TXREQ_IEN <= WB_DAT_W[ims_pkg::BIT_TXREQ_IEN];
			CMP_IEN   <= WB_DAT_W[ims_pkg::BIT_CMP_IEN];
		end
	end

	//------------------------------------------------------------
	// status register
	//------------------------------------------------------------
	// underflow is only recorded while the tx request enable is on
	assign uflow_set = TX_EMPTY_END & TXREQ_IEN;

	// a start wins if both are seen together; they cannot legally coincide
	always_comb begin
		bus_occ_next = bus_occ_reg;
		if (lines.stop) begin
			bus_occ_next = 1'b0;
		end
		if (lines.start) begin
			bus_occ_next = 1'b1;
		end
	end

	// line mirrors and busy are plain state, never cleared by a read
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			clk_filt_reg <= ims_pkg::STATUS_RESET[ims_pkg::BIT_CLK_FILT];
			dat_filt_reg <= ims_pkg::STATUS_RESET[ims_pkg::BIT_DAT_FILT];
			bus_occ_reg  <= ims_pkg::STATUS_RESET[ims_pkg::BIT_BUS_OCC];
		end else begin
			clk_filt_reg <= lines.scl;
			dat_filt_reg <= lines.sda;
			bus_occ_reg  <= bus_occ_next;
		end
	end

	// sticky flags: a set in the clearing cycle is kept
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			uflow_reg     <= ims_pkg::STATUS_RESET[ims_pkg::BIT_TX_UFLOW];
			self_stop_reg <= ims_pkg::STATUS_RESET[ims_pkg::BIT_SELF_STOP];
			oflow_reg     <= ims_pkg::STATUS_RESET[ims_pkg::BIT_RX_OFLOW];
		end else begin
			if (uflow_set) begin
				uflow_reg <= 1'b1;
			end else if (rd_status) begin
				uflow_reg <= 1'b0;
			end
			// only this master's own stop counts, not a stop seen on the bus
			if (SELF_STOP_DRIVEN) begin
				self_stop_reg <= 1'b1;
			end else if (rd_status) begin
				self_stop_reg <= 1'b0;
			end
			if (RX_PUSH && RX_FULL) begin
				oflow_reg <= 1'b1;
			end else if (rd_status) begin
				oflow_reg <= 1'b0;
			end
		end
	end

	// spare bits are tied low so they always read as zero
	always_comb begin
		status_word                         = 16'h0000;
		status_word[ims_pkg::BIT_CLK_FILT]  = clk_filt_reg;
		status_word[ims_pkg::BIT_DAT_FILT]  = dat_filt_reg;
		status_word[ims_pkg::BIT_TX_UFLOW]  = uflow_reg;
		status_word[ims_pkg::BIT_SELF_STOP] = self_stop_reg;
		status_word[ims_pkg::BIT_BUS_OCC]   = bus_occ_reg;
		status_word[ims_pkg::BIT_RX_OFLOW]  = oflow_reg;
	end

	//------------------------------------------------------------
	// interrupt status, mask and output
	//------------------------------------------------------------
	// the self-stop flag feeds no event; software reads it after a stop
	always_comb begin
		irq_event = '0;
		irq_event[ims_pkg::IRQ_TX_BYTE] = TX_BYTE_DONE & TXREQ_IEN;
		irq_event[ims_pkg::IRQ_STOP]    = lines.stop & CMP_IEN;
		irq_event[ims_pkg::IRQ_UFLOW]   = uflow_set;
		irq_event[ims_pkg::IRQ_OFLOW]   = RX_PUSH & RX_FULL;
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			irq_stat_reg <= ims_pkg::IRQ_RESET;
		end else begin
			// events win over the read that clears
			irq_stat_reg <= (rd_irq ? '0 : irq_stat_reg) | irq_event;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			irq_mask_reg <= ims_pkg::IRQ_RESET;
		end else if (wr_en && WB_ADR == ims_pkg::ADDR_IRQ_MASK && WB_SEL[0]) begin
			irq_mask_reg <= WB_DAT_W[ims_pkg::IRQ_BITS-1:0];
		end
	end

	// registered so the output comes from a flop; one cycle behind status
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(irq_stat_reg & irq_mask_reg);
		end
	end
endmodule
`default_nettype wire

// >>> ims_checker.sv
// port-level assertions for the master status flags block
`timescale 1ns/1ps
`default_nettype none
module ims_checker #(
	parameter int FILT_LEN = 4
) (
	// clock and reset
	input wire logic        CORE_CLK,
	input wire logic        RST,
	// wishbone slave
	input wire logic [31:0] WB_ADR,
	input wire logic [31:0] WB_DAT_W,
	input wire logic [3:0]  WB_SEL,
	input wire logic        WB_WE,
	input wire logic        WB_CYC,
	input wire logic        WB_STB,
	input wire logic [31:0] WB_DAT_R,
	input wire logic        WB_ACK,
	// lines and enables
	input wire logic        SCL_IN,
	input wire logic        SDA_IN,
	input wire logic        TXREQ_IEN,
	input wire logic        CMP_IEN
);
	// ----------------
	// helper logic
	// ----------------
	logic       req;
	logic       st_rd_reg;
	logic       um_rd_reg;
	logic       wr_ct_reg;
	logic [1:0] dw_reg;
	logic [7:0] quiet_reg;
	assign req = WB_CYC && WB_STB;
	always_ff @(posedge CORE_CLK) begin
		st_rd_reg <= req && !WB_WE && WB_ADR == ims_pkg::ADDR_STATUS;
		um_rd_reg <= req && !WB_WE && !(WB_ADR inside {ims_pkg::ADDR_STATUS,
			ims_pkg::ADDR_CONTROL, ims_pkg::ADDR_IRQ_STAT, ims_pkg::ADDR_IRQ_MASK});
		wr_ct_reg <= req && WB_WE && WB_SEL[0] && WB_ADR == ims_pkg::ADDR_CONTROL;
		dw_reg    <= WB_DAT_W[1:0];
	end
	// line bits are only comparable once the pins have been quiet past the filter lag
	always_ff @(posedge CORE_CLK) begin
		if (RST || SCL_IN != $past(SCL_IN) || SDA_IN != $past(SDA_IN))
			quiet_reg <= 8'h00;
		else if (quiet_reg != 8'hFF)
			quiet_reg <= quiet_reg + 8'h01;
	end
	// ----------------
	// assertions
	// ----------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	ack_one_cycle_a: assert property (WB_ACK |=> !WB_ACK)
		else $error("ack longer than one cycle");
	ack_latency_a: assert property ($rose(WB_STB) && WB_CYC |=> WB_ACK)
		else $error("ack not one cycle after request");
	ack_idle_a: assert property (!req |=> !WB_ACK)
		else $error("ack without request");
	status_reserved_a: assert property (WB_ACK && st_rd_reg |->
		WB_DAT_R[31:15] == 17'h0 && WB_DAT_R[8:0] == 9'h0) else $error("status spare bits set");
	line_bits_a: assert property (WB_ACK && st_rd_reg && quiet_reg > FILT_LEN + 8 |->
		WB_DAT_R[14:13] == {SCL_IN, SDA_IN}) else $error("line bits differ from pins");
	unmapped_zero_a: assert property (WB_ACK && um_rd_reg |-> WB_DAT_R == 32'h0)
		else $error("unmapped read not zero");
	ien_write_a: assert property (WB_ACK && wr_ct_reg |->
		TXREQ_IEN == dw_reg[0] && CMP_IEN == dw_reg[1]) else $error("enables not written");
	ien_hold_a: assert property (!(req && WB_WE) |=> $stable({TXREQ_IEN, CMP_IEN}))
		else $error("enables changed without write");
	cov_status: cover property (WB_ACK && st_rd_reg && quiet_reg > FILT_LEN + 8);
	cov_ctrl: cover property (WB_ACK && wr_ct_reg && CMP_IEN);
	cov_unmapped: cover property (WB_ACK && um_rd_reg);
endmodule
bind ims_status_top ims_checker #(.FILT_LEN(FILT_LEN)) ims_checker_i (.CORE_CLK(CORE_CLK),
	.RST(RST), .WB_ADR(WB_ADR), .WB_DAT_W(WB_DAT_W), .WB_SEL(WB_SEL), .WB_WE(WB_WE),
	.WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_DAT_R(WB_DAT_R), .WB_ACK(WB_ACK),
	.SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .TXREQ_IEN(TXREQ_IEN), .CMP_IEN(CMP_IEN));
`default_nettype wire

// >>> ims_line_model.sv
// another bus master making start and stop conditions on pulled-up lines
`timescale 1ns/1ps
`default_nettype none
module ims_line_model #(
	parameter int HOLD = 12
) (
	// clock
	input  wire logic clk,
	// lines
	output var  logic scl,
	output var  logic sda
);
	// undriven lines sit high through their pull-ups
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// hold each level well past the filter lag so no edge is lost
	task automatic hold_c();
		repeat (HOLD) @(posedge clk);
	endtask
	task automatic start_c();
		sda <= 1'b0;
		hold_c();
		scl <= 1'b0;
		hold_c();
	endtask
	task automatic stop_c();
		sda <= 1'b0;
		hold_c();
		scl <= 1'b1;
		hold_c();
		sda <= 1'b1;
		hold_c();
	endtask
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the master status flags block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk, rst, we, cyc, stb, ack, rx_full, irq, scl, sda, tx_ien, cmp_ien;
	logic [31:0] adr, dw, dr, q, r;
	logic [3:0]  ev, m_irq, m_mask;
	logic [1:0]  m_ctl;
	logic [15:0] m_st;
	int          n_fail, checks, cyc_n, busy;
	ims_line_model ims_line_model_i (.clk(clk), .scl(scl), .sda(sda));
	ims_status_top #(.FILT_LEN(2)) ims_status_top_i (.CORE_CLK(clk), .RST(rst),
		.WB_ADR(adr), .WB_DAT_W(dw), .WB_SEL(4'hF), .WB_WE(we), .WB_CYC(cyc), .WB_STB(stb),
		.WB_DAT_R(dr), .WB_ACK(ack), .SCL_IN(scl), .SDA_IN(sda), .TX_EMPTY_END(ev[0]),
		.SELF_STOP_DRIVEN(ev[1]), .RX_PUSH(ev[2]), .RX_FULL(rx_full), .TX_BYTE_DONE(ev[3]),
		.TXREQ_IEN(tx_ien), .CMP_IEN(cmp_ien), .IRQ(irq));
	initial clk = 1'b0;
	always #20 clk = ~clk;
	// ----------------
	// checking and bus tasks
	// ----------------
	task automatic test_done();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			n_fail++;
			test_done();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d);
		adr <= a;
		we  <= w;
		dw  <= d;
		cyc <= 1'b1;
		stb <= 1'b1;
		do @(posedge clk); while (ack !== 1'b1);
		q = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic wr_ctl(input logic [1:0] c, input logic [3:0] m);
		wb(ims_pkg::ADDR_CONTROL, 1'b1, {30'h0, c});
		wb(ims_pkg::ADDR_IRQ_MASK, 1'b1, {28'h0, m});
		m_ctl = c;
		m_mask = m;
	endtask
	task automatic rd_status(input string nm);
		wb(ims_pkg::ADDR_STATUS, 1'b0, 32'h0);
		chk(nm, q, {16'h0, m_st | (busy ? 16'h0400 : 16'h6000)});
		m_st = 16'h0;
	endtask
	task automatic rd_irq();
		wb(ims_pkg::ADDR_IRQ_STAT, 1'b0, 32'h0);
		chk("irq status", q, {28'h0, m_irq});
		m_irq = 4'h0;
		chk("irq cleared", {31'h0, irq}, 32'h0);
	endtask
	// one event pulse, then the model follows and the irq line is compared
	task automatic pulse(input logic [3:0] v);
		ev <= v;
		@(posedge clk);
		ev <= 4'h0;
		repeat (2) @(posedge clk);
		m_st[12] = m_st[12] | (v[0] & m_ctl[0]);
		m_st[11] = m_st[11] | v[1];
		m_st[9]  = m_st[9] | (v[2] & rx_full);
		m_irq = m_irq | {v[2] & rx_full, v[0] & m_ctl[0], 1'b0, v[3] & m_ctl[0]};
		chk("irq", {31'h0, irq}, {31'h0, |(m_irq & m_mask)});
	endtask
	// ----------------
	// scenarios
	// ----------------
	initial begin
		void'($urandom(32'hC800));
		{rst, cyc, stb, we, adr, dw, ev, rx_full} = {1'b1, 72'h0};
		{m_st, m_irq, m_mask, m_ctl} = 26'h0;
		{busy, n_fail, checks, cyc_n} = 128'h0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		wb(ims_pkg::ADDR_STATUS, 1'b1, 32'hFFFF);
		rd_status("reset status");
		wb(32'h40020808, 1'b0, 32'h0);
		chk("unmapped", q, 32'h0);
		for (int i = 0; i < 4; i++) begin
			r = $urandom;
			wb(ims_pkg::ADDR_CONTROL, 1'b1, r);
			chk("enable pins", {30'h0, cmp_ien, tx_ien}, {30'h0, r[1:0]});
			wb(ims_pkg::ADDR_CONTROL, 1'b0, 32'h0);
			chk("control", q, {30'h0, r[1:0]});
		end
		wr_ctl(2'h3, 4'hF);
		pulse(4'b0011);
		rx_full <= 1'b1;
		pulse(4'b0100);
		rx_full <= 1'b0;
		pulse(4'b0100);
		rd_status("flags set");
		rd_status("flags cleared");
		rd_irq();
		wr_ctl(2'h2, 4'hF);
		pulse(4'b1011);
		rd_status("underflow gated");
		rd_irq();
		wr_ctl(2'h2, 4'hF);
		ims_line_model_i.start_c();
		busy = 1;
		rd_status("bus busy");
		ims_line_model_i.stop_c();
		busy = 0;
		m_irq[1] = 1'b1;
		chk("stop irq", {31'h0, irq}, 32'h1);
		rd_status("foreign stop");
		rd_irq();
		wr_ctl(2'h3, 4'h0);
		pulse(4'b1000);
		rd_irq();
		fork
			wb(ims_pkg::ADDR_STATUS, 1'b0, 32'h0);
			pulse(4'b0010);
		join
		chk("read during set", q, 32'h00006000);
		m_st = 16'h0800;
		rd_status("set beats clear");
		test_done();
	end
endmodule
`default_nettype wire
